// File: src/tocu_pkg.sv
/*
 package for the timer output compare unit: register offsets, field
 positions, reset values, mode codes and the carrier structs.
 assumes a classic wishbone master with 32-bit data and byte addresses.
*/
// Functional notes
// - compare counter with both compare values continuously
// - match flag sets one cycle after equality
// - flag requests interrupt; service or write-one clears
// - top and bottom handle extreme compare values
// - compare double buffered only in pwm modes
// - buffer loads active compare at top
// - software reaches buffer or active compare by mode
// - force strobe acts like match in non-pwm modes, no flag
// - counter write blocks matches next cycle
// - output state survives waveform mode change
// - output action bits apply at once
// - nonzero action overrides port value; direction stays
// - action zero leaves output state alone
// - counting ignores output action bits
// - action bits: polarity in pwm, set/clear/toggle otherwise
// - mode zero counts up and wraps
// - overflow flag sets on the max-to-zero wrap, at top in fast pwm, at bottom in phase-correct pwm
// - normal mode accepts counter writes anytime
// - mode two clears counter on match a
// - modes three and seven are fast pwm
// - modes one and five are phase-correct pwm
package tocu_pkg;

   localparam int unsigned ADR_W = 5;

   // register byte offsets
   localparam logic [ADR_W-1:0] OFS_CTRL_A = 5'h00;
   localparam logic [ADR_W-1:0] OFS_CTRL_B = 5'h04;
   localparam logic [ADR_W-1:0] OFS_COUNT  = 5'h08;
   localparam logic [ADR_W-1:0] OFS_CMP_A  = 5'h0c;
   localparam logic [ADR_W-1:0] OFS_CMP_B  = 5'h10;
   localparam logic [ADR_W-1:0] OFS_FLAGS  = 5'h14;
   localparam logic [ADR_W-1:0] OFS_MASK   = 5'h18;
   localparam logic [ADR_W-1:0] OFS_PORT   = 5'h1c;

   // field positions
   localparam int unsigned CA_ACT_A_LSB = 6;
   localparam int unsigned CA_ACT_B_LSB = 4;
   localparam int unsigned CA_WGM_LSB   = 0;
   localparam int unsigned CB_FORCE_A   = 7;
   localparam int unsigned CB_FORCE_B   = 6;
   localparam int unsigned CB_WGM2      = 3;
   localparam int unsigned CB_RUN       = 0;
   localparam int unsigned FL_OVF       = 0;
   localparam int unsigned FL_MATCH_LSB = 1;
   localparam int unsigned PT_VAL_LSB   = 0;
   localparam int unsigned PT_DIR_LSB   = 4;

   // reset values and counter extremes
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [7:0] CNT_MAX    = 8'hff;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;

   // waveform mode codes
   localparam logic [2:0] WM_NORMAL    = 3'h0;
   localparam logic [2:0] WM_CLR_MATCH = 3'h2;

   typedef enum logic [1:0] {
      ACT_NONE   = 2'h0,
      ACT_TOGGLE = 2'h1,
      ACT_CLEAR  = 2'h2,
      ACT_SET    = 2'h3
   } tocu_act_e;

   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [3:0]       sel;
      logic [ADR_W-1:0] adr;
      logic [31:0]      dat;
   } tocu_wb_req_s;

   typedef struct packed {
      logic [1:0] out;
      logic [1:0] oe_n;
   } tocu_pin_s;

endpackage

// File: src/tocu_output_compare.sv
/*
 timer output compare unit: 8-bit counter, two compare channels with
 double buffering, match and overflow flags, waveform generator and
 port pin override, reached over a classic wishbone slave.
 assumes a single 40 MHz clock; the run bit stands for the timer clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tocu_output_compare
   import tocu_pkg::*;
#(
   parameter int unsigned CNT_W = 8
)
(
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire tocu_wb_req_s wb_req,
   output logic [31:0]       wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic [2:0]   irq_ack,
   output logic [2:0]        irq_req,
   output tocu_pin_s         pin
);

   // the channel logic is written for an 8-bit counter only
   if (CNT_W != 8)
   begin : g_bad_width
      $error("tocu_output_compare supports CNT_W of 8 only");
   end

   logic [7:0] ctrl_a_reg;
   logic [1:0] force_reg;
   logic       wgm2_reg;
   logic       run_reg;
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic       down_reg;
   logic       down_next;
   logic [7:0] buf_reg [2];
   logic [7:0] act_reg [2];
   logic [2:0] flag_reg;
   logic [2:0] mask_reg;
   logic [1:0] port_val_reg;
   logic [1:0] port_dir_reg;
   logic       block_reg;
   logic [1:0] match_q_reg;
   logic [1:0] match_dn_reg;
   logic [1:0] oc_reg;
   logic       ack_reg;
   logic [31:0] rd_reg;
   tocu_pin_s  pin_reg;

   logic       wb_hit;
   logic       wr_en;
   logic [7:0] wdata;
   logic [7:0] rd_byte;
   logic [2:0] wgm;
   logic       pwm;
   logic       fast;
   logic       pc;
   logic       clr_mode;
   logic [7:0] top_val;
   logic       at_top;
   logic       at_bottom;
   logic       at_max;
   logic       cnt_wr;
   logic       tick;
   logic       wrap_evt;
   logic       ovf_set;
   logic [1:0] eq;
   logic [1:0] match_raw;
   logic [1:0] force_hit;
   logic [1:0] act_bits [2];

   // bus decode; a write lands at the edge where the master sees ack
   assign wb_hit = wb_req.cyc & wb_req.stb;
   assign wr_en  = wb_hit & wb_req.we & ack_reg & wb_req.sel[0];
   assign wdata  = wb_req.dat[7:0];
   assign cnt_wr = wr_en & (wb_req.adr == OFS_COUNT);

   // mode decode, from waveform bits only
   assign wgm      = {wgm2_reg, ctrl_a_reg[CA_WGM_LSB +: 2]};
   assign pwm      = wgm[0];
   assign fast     = pwm & wgm[1];
   assign pc       = pwm & ~wgm[1];
   assign clr_mode = (wgm == WM_CLR_MATCH);
   assign top_val  = ((pwm & wgm[2]) | clr_mode) ? act_reg[0] : CNT_MAX;
   assign at_top    = (cnt_reg == top_val);
   assign at_bottom = (cnt_reg == CNT_BOTTOM);
   assign at_max    = (cnt_reg == CNT_MAX);
   assign tick      = run_reg;
   assign wrap_evt  = tick & ~cnt_wr & fast & at_top;
   assign act_bits[0] = ctrl_a_reg[CA_ACT_A_LSB +: 2];
   assign act_bits[1] = ctrl_a_reg[CA_ACT_B_LSB +: 2];

   // counter sequence per mode; a software write wins
   always_comb
   begin
      cnt_next  = cnt_reg;
      down_next = down_reg;
      if (cnt_wr)
      begin
         cnt_next = wdata;
      end
      else if (tick)
      begin
         if (pc)
         begin
            down_next = (~down_reg & at_top) | (down_reg & ~at_bottom);
            cnt_next  = down_next ? cnt_reg - 8'h01 : cnt_reg + 8'h01;
         end
         else if (fast | clr_mode)
         begin
            down_next = 1'b0;
            cnt_next  = at_top ? CNT_BOTTOM : cnt_reg + 8'h01;
         end
         else
         begin
            down_next = 1'b0;
            cnt_next  = cnt_reg + 8'h01;
         end
      end
   end

   // overflow event per mode
   always_comb
   begin
      if (cnt_wr | ~tick)
      begin
         ovf_set = 1'b0;
      end
      else if (pc)
      begin
         ovf_set = down_reg & at_bottom;
      end
      else if (fast)
      begin
         ovf_set = at_top;
      end
      else
      begin
         ovf_set = at_max & (cnt_next == CNT_BOTTOM);
      end
   end

   // counter and direction
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cnt_reg  <= RST_BYTE;
         down_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= cnt_next;
         down_reg <= down_next;
      end
   end

   // control registers written from the bus
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ctrl_a_reg   <= RST_BYTE;
         force_reg    <= 2'h0;
         wgm2_reg     <= 1'b0;
         run_reg      <= 1'b0;
         mask_reg     <= 3'h0;
         port_val_reg <= 2'h0;
         port_dir_reg <= 2'h0;
      end
      else
      begin
         force_reg <= 2'h0;                                      // strobes last one cycle
         if (wr_en)
         begin
            case (wb_req.adr)
               OFS_CTRL_A:
               begin
                  ctrl_a_reg <= wdata;
               end
               OFS_CTRL_B:
               begin
                  force_reg <= {wdata[CB_FORCE_B], wdata[CB_FORCE_A]};
                  wgm2_reg  <= wdata[CB_WGM2];
                  run_reg   <= wdata[CB_RUN];
               end
               OFS_MASK:
               begin
                  mask_reg <= wdata[2:0];
               end
               OFS_PORT:
               begin
                  port_val_reg <= wdata[PT_VAL_LSB +: 2];
                  port_dir_reg <= wdata[PT_DIR_LSB +: 2];
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   // match blocking for one cycle after a counter write
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         block_reg <= 1'b0;
      end
      else
      begin
         block_reg <= cnt_wr;
      end
   end

   // overflow flag: set wins over any clear
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         flag_reg[FL_OVF] <= 1'b0;
      end
      else if (ovf_set)
      begin
         flag_reg[FL_OVF] <= 1'b1;
      end
      else if (irq_ack[FL_OVF] |
               (wr_en & (wb_req.adr == OFS_FLAGS) & wdata[FL_OVF]))
      begin
         flag_reg[FL_OVF] <= 1'b0;
      end
   end

   // per channel: buffer, active compare, match, flag and output state
   for (genvar i = 0; i < 2; i++)
   begin : g_chan
      localparam logic [ADR_W-1:0] OFS_CMP = (i == 0) ? OFS_CMP_A : OFS_CMP_B;
      localparam int unsigned      FB      = FL_MATCH_LSB + i;
      logic cmp_wr;
      logic ocr_top;
      logic ocr_bottom;

      assign cmp_wr       = wr_en & (wb_req.adr == OFS_CMP);
      assign eq[i]        = (cnt_reg == act_reg[i]);
      assign match_raw[i] = tick & eq[i] & ~block_reg;
      assign force_hit[i] = force_reg[i] & ~pwm;
      assign ocr_top      = (act_reg[i] == top_val);
      assign ocr_bottom   = (act_reg[i] == CNT_BOTTOM);

      // buffer takes every write; active takes it only without buffering
      always_ff @(posedge clk or posedge reset)
      begin
         if (reset)
         begin
            buf_reg[i] <= RST_BYTE;
            act_reg[i] <= RST_BYTE;
         end
         else
         begin
            if (cmp_wr)
            begin
               buf_reg[i] <= wdata;
            end
            if (cmp_wr & ~pwm)
            begin
               act_reg[i] <= wdata;
            end
            else if (pwm & tick & ~cnt_wr & at_top)
            begin
               act_reg[i] <= buf_reg[i];
            end
         end
      end

      // match pipeline; remembers slope with extremes folded in
      always_ff @(posedge clk or posedge reset)
      begin
         if (reset)
         begin
            match_q_reg[i]  <= 1'b0;
            match_dn_reg[i] <= 1'b0;
         end
         else
         begin
            match_q_reg[i]  <= match_raw[i];
            match_dn_reg[i] <= ocr_top ? 1'b1 : (ocr_bottom ? 1'b0 : down_reg);
         end
      end

      // match flag: set wins over service or write-one clear
      always_ff @(posedge clk or posedge reset)
      begin
         if (reset)
         begin
            flag_reg[FB] <= 1'b0;
         end
         else if (match_raw[i])                                  // set at the edge ending the match
         begin
            flag_reg[FB] <= 1'b1;
         end
         else if (irq_ack[FB] | (wr_en & (wb_req.adr == OFS_FLAGS) & wdata[FB]))
         begin
            flag_reg[FB] <= 1'b0;
         end
      end

      // waveform generator; mode changes never touch the state
      always_ff @(posedge clk or posedge reset)
      begin
         if (reset)
         begin
            oc_reg[i] <= 1'b0;
         end
         else if (~pwm)
         begin
            if (match_q_reg[i] | force_hit[i])
            begin
               case (act_bits[i])
                  ACT_TOGGLE: oc_reg[i] <= ~oc_reg[i];
                  ACT_CLEAR:  oc_reg[i] <= 1'b0;
                  ACT_SET:    oc_reg[i] <= 1'b1;
                  default:    oc_reg[i] <= oc_reg[i];
               endcase
            end
         end
         else if (fast)
         begin
            if (act_bits[i][1] & wrap_evt)
            begin
               oc_reg[i] <= (act_bits[i] == ACT_CLEAR);
            end
            else if (act_bits[i][1] & match_q_reg[i] & ~ocr_top)
            begin
               oc_reg[i] <= (act_bits[i] == ACT_SET);
            end
            else if ((i == 0) & wgm[2] & match_q_reg[i] &
                     (act_bits[i] == ACT_TOGGLE))
            begin
               oc_reg[i] <= ~oc_reg[i];
            end
         end
         else if (pc & act_bits[i][1] & match_q_reg[i])
         begin
            oc_reg[i] <= match_dn_reg[i] ^ (act_bits[i] == ACT_SET);
         end
      end

      // pin: override when any action bit is set, direction from port
      always_ff @(posedge clk or posedge reset)
      begin
         if (reset)
         begin
            pin_reg.out[i]  <= 1'b0;
            pin_reg.oe_n[i] <= 1'b1;
         end
         else
         begin
            pin_reg.out[i]  <= (|act_bits[i]) ? oc_reg[i] : port_val_reg[i];
            pin_reg.oe_n[i] <= ~port_dir_reg[i];
         end
      end
   end

   // read mux; force strobes always read zero
   always_comb
   begin
      case (wb_req.adr)
         OFS_CTRL_A: rd_byte = ctrl_a_reg;
         OFS_CTRL_B: rd_byte = {4'h0, wgm2_reg, 2'h0, run_reg};
         OFS_COUNT:  rd_byte = cnt_reg;
         OFS_CMP_A:  rd_byte = pwm ? buf_reg[0] : act_reg[0];
         OFS_CMP_B:  rd_byte = pwm ? buf_reg[1] : act_reg[1];
         OFS_FLAGS:  rd_byte = {5'h00, flag_reg};
         OFS_MASK:   rd_byte = {5'h00, mask_reg};
         OFS_PORT:   rd_byte = {2'h0, port_dir_reg, 2'h0, port_val_reg};
         default:    rd_byte = RST_BYTE;
      endcase
   end

   // wishbone answer one cycle after the strobe, dropped the next
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ack_reg <= 1'b0;
         rd_reg  <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= wb_hit & ~ack_reg;
         if (wb_hit & ~ack_reg)
         begin
            rd_reg <= {24'h00_0000, rd_byte};
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rd_reg;
   assign irq_req  = flag_reg & mask_reg;
   assign pin      = pin_reg;

   // flag follows an unblocked equality by exactly one cycle
   flag_follows_a: assert property (@(posedge clk) disable iff (reset)
      match_raw[0] |=> flag_reg[FL_MATCH_LSB])
      else $error("match flag a not set one cycle after match");

   // a counter write suppresses matches in the next cycle
   write_blocks_a: assert property (@(posedge clk) disable iff (reset)
      cnt_wr |=> ##1 !match_q_reg[0] && !match_q_reg[1])
      else $error("match seen right after counter write");

   // force strobe never sets a flag on its own
   force_noflag_a: assert property (@(posedge clk) disable iff (reset)
      (force_reg[0] && !match_raw[0] && !flag_reg[FL_MATCH_LSB])
      |=> !flag_reg[FL_MATCH_LSB])
      else $error("force strobe set the match flag");

   // forced toggle flips the output state in non-pwm modes
   force_toggle_a: assert property (@(posedge clk) disable iff (reset)
      (force_hit[0] && !match_q_reg[0] && act_bits[0] == ACT_TOGGLE)
      |=> oc_reg[0] != $past(oc_reg[0]))
      else $error("force toggle did not flip output a");

   // action zero freezes the state in every mode
   no_action_a: assert property (@(posedge clk) disable iff (reset)
      (act_bits[1] == ACT_NONE) |=> $stable(oc_reg[1]))
      else $error("output b changed with action zero");

   // overflow sets on the wrap in normal mode
   normal_wrap_a: assert property (@(posedge clk) disable iff (reset)
      (wgm == WM_NORMAL && tick && !cnt_wr && at_max)
      |=> cnt_reg == CNT_BOTTOM && flag_reg[FL_OVF])
      else $error("normal mode wrap missed overflow");

   // pin shows the state one cycle later when overridden
   pin_override_a: assert property (@(posedge clk) disable iff (reset)
      (act_bits[0] != ACT_NONE) ##1 (act_bits[0] != ACT_NONE)
      |-> pin.out[0] == $past(oc_reg[0]))
      else $error("pin a not driven by output state");

   // pwm keeps the active compare until the top of the count
   buffer_hold_a: assert property (@(posedge clk) disable iff (reset)
      (pwm && !(tick && at_top)) |=> act_reg[1] == $past(act_reg[1]))
      else $error("active compare b changed away from top");

   // wishbone ack is a single-cycle pulse
   ack_pulse_a: assert property (@(posedge clk) disable iff (reset)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// File: verif/tocu_pad_model.sv
/*
 pad model for the two compare pins: works out what each port pin shows.
 assumes pin.oe_n low means the unit drives the pad; a released pad is pulled up.
*/
`timescale 1ns/1ps
`default_nettype none
module tocu_pad_model
   import tocu_pkg::*;
(
   input  wire tocu_pin_s pin,
   output logic [1:0]     pad
);
   // a released pad floats to the pull-up level, so a stale value never shows
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         pad[i] = pin.oe_n[i] ? 1'b1 : pin.out[i];
      end
   end
endmodule
`default_nettype wire

// File: verif/testbench.sv
/*
 self-checking bench for the timer output compare unit: counting, flags,
 match blocking, force strobes, pin override and compare buffering.
 assumes the 40 MHz clock and the one-cycle wishbone answer of the unit.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) check(nm, 32'(ex), 32'(gt))
module testbench
   import tocu_pkg::*;
;
   logic         clk;
   logic         reset;
   tocu_wb_req_s wb_req;
   logic [31:0]  wb_dat_o;
   logic         wb_ack_o;
   logic [2:0]   irq_ack;
   logic [2:0]   irq_req;
   tocu_pin_s    pin;
   logic [1:0]   pad;
   logic [31:0]  rd;
   int           failures;
   int           n_compared;

   tocu_output_compare #(
      .CNT_W (8)
   ) u_dut (
      .clk      (clk),
      .reset    (reset),
      .wb_req   (wb_req),
      .wb_dat_o (wb_dat_o),
      .wb_ack_o (wb_ack_o),
      .irq_ack  (irq_ack),
      .irq_req  (irq_req),
      .pin      (pin)
   );

   tocu_pad_model u_pad (
      .pin (pin),
      .pad (pad)
   );

   // 40 MHz clock
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // comparison and verdict
   task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] gt);
      n_compared++;
      if (gt !== ex)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, ex, gt);
      end
   endtask

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // one classic wishbone cycle, held until ack is sampled
   task automatic wb_xfer(input logic wr_en, input logic [4:0] adr, input logic [7:0] val);
      int n;
      n = 0;
      @(posedge clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: wr_en, sel: 4'hf, adr: adr, dat: {24'h0, val}};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      `CHK("bus ack", 1'b1, wb_ack_o);
      rd = wb_dat_o;
      wb_req <= '0;
   endtask

   task automatic wr(input logic [4:0] adr, input logic [7:0] val);
      wb_xfer(1'b1, adr, val);
   endtask

   task automatic rd_chk(input string nm, input logic [4:0] adr, input logic [7:0] ex);
      wb_xfer(1'b0, adr, 8'h00);
      `CHK(nm, ex, rd);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask

   // state lands one edge after the strobe, the pin one edge later
   task automatic pad_chk(input int ch, input logic ex);
      cycles(3);
      `CHK("pad level", ex, pad[ch]);
   endtask

   task automatic force_ch(input int ch);
      wr(OFS_CTRL_B, 8'(1 << (ch ? CB_FORCE_B : CB_FORCE_A)));
   endtask

   // short run from a start count, then the flags it left
   task automatic burst(input logic [7:0] start, input logic [7:0] ex);
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_COUNT, start);
      wr(OFS_CTRL_B, 8'h01);
      cycles(3);
      wr(OFS_CTRL_B, 8'h00);
      rd_chk("burst flags", OFS_FLAGS, ex);
   endtask

   task automatic t_reset();
      `CHK("pads idle", 2'h3, pad);
      rd_chk("ctrl a", OFS_CTRL_A, 8'h00);
      rd_chk("count", OFS_COUNT, 8'h00);
      rd_chk("unmapped", 5'h02, 8'h00);
   endtask

   // wrap through zero sets overflow and both zero compares
   task automatic t_normal();
      wr(OFS_COUNT, 8'hf0);
      wr(OFS_CTRL_B, 8'h01);
      cycles(25);
      wr(OFS_CTRL_B, 8'h00);
      wb_xfer(1'b0, OFS_COUNT, 8'h00);
      `CHK("wrapped", 1'b1, rd[7:0] < 8'h20);
      rd_chk("flags", OFS_FLAGS, 8'h07);
      wr(OFS_FLAGS, 8'h07);
      rd_chk("flags clear", OFS_FLAGS, 8'h00);
   endtask

   // blocked match after a counter write, flag timing, service clear
   task automatic t_match();
      wr(OFS_MASK, 8'h02);
      wr(OFS_CMP_A, 8'h20);
      wr(OFS_CTRL_B, 8'h01);
      wr(OFS_COUNT, 8'h20);
      cycles(4);
      `CHK("blocked match", 1'b0, irq_req[1]);
      wr(OFS_COUNT, 8'h1e);
      cycles(2);
      #1;
      `CHK("flag early", 1'b0, irq_req[1]);
      cycles(1);
      #1;
      `CHK("flag set", 1'b1, irq_req[1]);
      @(posedge clk) irq_ack <= 3'h2;
      @(posedge clk) irq_ack <= 3'h0;
      #1;
      `CHK("serviced", 1'b0, irq_req[1]);
      wr(OFS_CTRL_B, 8'h00);
   endtask

   // force strobes on both channels with every output action
   task automatic t_force();
      logic [7:0] acts [3] = '{8'h02, 8'h01, 8'h01};
      int         lsb;
      wr(OFS_FLAGS, 8'h07);
      for (int ch = 0; ch < 2; ch++)
      begin
         lsb = ch ? CA_ACT_B_LSB : CA_ACT_A_LSB;
         wr(OFS_CTRL_A, 8'(3 << lsb));
         force_ch(ch);
         wr(OFS_PORT, 8'h30);
         pad_chk(ch, 1'b1);
         for (int k = 0; k < 3; k++)
         begin
            wr(OFS_CTRL_A, 8'(acts[k] << lsb));
            force_ch(ch);
            pad_chk(ch, k[0]);
         end
         wr(OFS_PORT, 8'h33);
         wr(OFS_CTRL_A, 8'h00);
         force_ch(ch);
         pad_chk(ch, 1'b1);
         wr(OFS_CTRL_A, 8'(1 << lsb));
         pad_chk(ch, 1'b0);
         wr(OFS_PORT, 8'h30);
      end
      rd_chk("flags", OFS_FLAGS, 8'h00);
      rd_chk("force bits", OFS_CTRL_B, 8'h00);
   endtask

   // fast pwm: buffered compare loads only at top
   task automatic t_pwm();
      wr(OFS_CTRL_A, 8'hc0);
      wr(OFS_CMP_A, 8'h10);
      wr(OFS_CTRL_B, 8'h80);
      wr(OFS_CTRL_A, 8'h83);
      pad_chk(0, 1'b1);
      wr(OFS_CTRL_B, 8'h80);
      pad_chk(0, 1'b1);
      wr(OFS_CMP_A, 8'h40);
      rd_chk("cmp buffer", OFS_CMP_A, 8'h40);
      burst(8'h0e, 8'h02);
      wr(OFS_CTRL_B, 8'h01);
      cycles(300);
      wr(OFS_CTRL_B, 8'h00);
      burst(8'h0e, 8'h00);
      burst(8'h3e, 8'h02);
   endtask

   // clear on match a, with output actions set
   task automatic t_clear();
      wr(OFS_CTRL_A, 8'hf2);
      wr(OFS_CMP_A, 8'h08);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_FLAGS, 8'h07);
      wr(OFS_CTRL_B, 8'h01);
      cycles(40);
      wr(OFS_CTRL_B, 8'h00);
      wb_xfer(1'b0, OFS_COUNT, 8'h00);
      `CHK("clear count", 1'b1, rd[7:0] <= 8'h08);
      rd_chk("clear flags", OFS_FLAGS, 8'h06);
   endtask

   // phase-correct: turns at top, overflow and zero match at bottom
   task automatic t_phase();
      wr(OFS_CTRL_A, 8'h81);
      burst(8'hfa, 8'h00);
      rd_chk("turned at top", OFS_COUNT, 8'hfe);
      burst(8'h03, 8'h05);
      rd_chk("turned at bottom", OFS_COUNT, 8'h03);
      wr(OFS_MASK, 8'h05);
      cycles(1);
      `CHK("irq lines", 3'h5, irq_req);
   endtask

   // main sequence
   initial
   begin
      failures = 0;
      n_compared = 0;
      reset = 1'b1;
      irq_ack = 3'h0;
      wb_req = '0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_normal();
      t_match();
      t_force();
      t_pwm();
      t_clear();
      t_phase();
      report_and_stop();
   end

   // watchdog well beyond the roughly 700 cycles the run needs
   initial
   begin
      repeat (8000) @(posedge clk);
      failures++;
      report_and_stop();
   end
endmodule
`default_nettype wire
